// >>> wip_pkg.sv
// Shared constants and types for the wakeup and pending-flag block
`default_nettype none
package wip_pkg;
	// Bus shape
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Event sources, one bit each
	localparam int NSRC     = 5;
	localparam int SRC_LVD  = 0;
	localparam int SRC_RTI  = 1;
	localparam int SRC_MODULO_TIMER = 2;
	localparam int SRC_ANALOG_COMPARATOR = 3;
	localparam int SRC_KBD  = 4;
	// Synchronous timer overflow cannot wake from stop
	localparam logic [NSRC-1:0] STOP_CAPABLE = 5'h1b;
	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFF_FLAGS   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_ENABLE  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_MASK    = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_PENDING = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_KBSC    = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_OPTION  = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_STATE   = 8'h18;
	// Field positions
	localparam int KB_FLAG_BIT     = 0;
	localparam int KB_EN_BIT       = 1;
	localparam int KB_ACK_BIT      = 2;
	localparam int OPT_STOP_PERMIT = 0;
	localparam int OPT_ANALOG_COMPARATOR_EN     = 1;
	// Reset values
	localparam logic [NSRC-1:0] RST_ENABLE = 5'h00;
	localparam logic [NSRC-1:0] RST_MASK   = 5'h00;
	localparam logic [1:0]      RST_OPTION = 2'h0;
	// Timing: bus clock and wait recovery in bus cycles
	localparam int         CLK_HZ        = 25_000_000;
	localparam int         WAKE_CYCLES   = 3;
	localparam logic [1:0] WAKE_CNT_INIT = 2'(WAKE_CYCLES - 2);
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Power states, one-hot
	typedef enum logic [4:0] {
		pwr_run     = 5'h01,
		pwr_wait    = 5'h02,
		pwr_stop    = 5'h04,
		pwr_recover = 5'h08,
		pwr_resume  = 5'h10
	} wip_pwr_type;
	// AXI4-Lite carriers
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} wip_axi_req_type;
	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} wip_axi_rsp_type;
endpackage
`default_nettype wire

// >>> wip_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module wip_sync #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Raw pins and cleaned result
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);
	import wip_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] lvl;
		logic [WIDTH-1:0] rise;
	} wip_sync_type;

	wip_sync_type q;
	wip_sync_type d;
	logic [WIDTH-1:0] agree;

	////////////////////////////////////////////////////////////////////////
	// A change counts only once the last two stages agree
	always_comb begin
		agree = q.s2 ~^ q.s3;
		d = q;
		d.s1 = pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.lvl = (agree & q.s3) | (~agree & q.lvl);
		d.rise = agree & q.s3 & ~q.lvl;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level = q.lvl;
	assign rise  = q.rise;
endmodule
`default_nettype wire

// >>> wip_axil.sv
// AXI4-Lite slave front end with simple register strobes
`default_nettype none
module wip_axil (
	// Clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// Bus
	input  wire wip_pkg::wip_axi_req_type axi_req,
	output var   wip_pkg::wip_axi_rsp_type axi_rsp,
	// Write strobe to register file
	output logic                          wr_en,
	output logic [wip_pkg::ADDR_W-1:0]    wr_addr,
	output logic [wip_pkg::DATA_W-1:0]    wr_data,
	output logic [3:0]                    wr_strb,
	input  wire logic                     wr_err,
	// Read path from register file
	output logic [wip_pkg::ADDR_W-1:0]    rd_addr,
	input  wire logic [wip_pkg::DATA_W-1:0] rd_data,
	input  wire logic                     rd_err
);
	import wip_pkg::*;

	typedef struct packed {
		logic              aw_have;
		logic [ADDR_W-1:0] awaddr;
		logic              w_have;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rpend;
		logic [ADDR_W-1:0] araddr;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
		logic              awrdy;
		logic              wrdy;
		logic              arrdy;
	} wip_axil_type;

	// Readies come from flops so every bus output is registered
	localparam wip_axil_type AXIL_RESET = '{awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1, default: '0};

	wip_axil_type q;
	wip_axil_type d;
	logic         wr_go;

	////////////////////////////////////////////////////////////////////////
	// Address and data are held separately so either may come first
	always_comb begin
		d = q;
		wr_go = q.aw_have & q.w_have & ~q.bvalid;
		if (axi_req.awvalid && !q.aw_have && !q.bvalid) begin
			d.aw_have = 1'b1;
			d.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && !q.w_have && !q.bvalid) begin
			d.w_have = 1'b1;
			d.wdata = axi_req.wdata;
			d.wstrb = axi_req.wstrb;
		end
		if (wr_go) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (q.bvalid && axi_req.bready) begin
			d.bvalid = 1'b0;
		end
		if (axi_req.arvalid && !q.rpend && !q.rvalid) begin
			d.rpend = 1'b1;
			d.araddr = axi_req.araddr;
		end
		if (q.rpend) begin
			d.rpend = 1'b0;
			d.rvalid = 1'b1;
			d.rdata = rd_data;
			d.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (q.rvalid && axi_req.rready) begin
			d.rvalid = 1'b0;
		end
		d.awrdy = ~d.aw_have & ~d.bvalid;
		d.wrdy = ~d.w_have & ~d.bvalid;
		d.arrdy = ~d.rpend & ~d.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= AXIL_RESET;
		end else begin
			q <= d;
		end
	end

	assign axi_rsp.awready = q.awrdy;
	assign axi_rsp.wready  = q.wrdy;
	assign axi_rsp.bvalid  = q.bvalid;
	assign axi_rsp.bresp   = q.bresp;
	assign axi_rsp.arready = q.arrdy;
	assign axi_rsp.rvalid  = q.rvalid;
	assign axi_rsp.rdata   = q.rdata;
	assign axi_rsp.rresp   = q.rresp;
	assign wr_en   = wr_go;
	assign wr_addr = q.awaddr;
	assign wr_data = q.wdata;
	assign wr_strb = q.wstrb;
	assign rd_addr = q.araddr;
endmodule
`default_nettype wire

// >>> wip_top.sv
// Wakeup control, event flags and central pending register
// How it works
// - An enabled event wakes the core from wait; from stop only if it is an asynchronous source.
// - Every event sets its own sticky flag for later polling.
// - In run or debug state events only set flags and pending bits, never change flow.
// - Five sources, each with its own flag and enable bit.
// - Only enabled sources may wake the core.
// - Wakeup resumes at next instruction; no vector fetch, counter held meanwhile.
// - Enabled event also sets its bit in the central pending register.
// - Enabled keyboard event sets both keyboard flag and keyboard pending bit.
// - Writing one to keyboard acknowledge clears both keyboard bits together.
// - Wait recovery takes three bus cycles before the next fetch.
// - Only asynchronous sources wake from stop; timer overflow cannot.
// - Asynchronous sources are synchronised to the bus clock first.
// - Stop wakeup waits for clock and regulator ready before resuming.
// - Disabled comparator leaves both its pins as plain I/O.
// - Wait instruction gates the core clock and holds the counter.
// - Stop without permit bit forces an illegal-opcode reset instead.
`default_nettype none
module wip_top (
	// Clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// Register bus
	input  wire wip_pkg::wip_axi_req_type  axi_req,
	output var   wip_pkg::wip_axi_rsp_type axi_rsp,
	// Event sources
	input  wire logic                      lvd_pin,
	input  wire logic                      rti_pin,
	input  wire logic                      analog_comparator_pin,
	input  wire logic                      kbd_pin,
	input  wire logic                      modulo_timer_overflow,
	// Core and power control
	input  wire logic                      wait_exec,
	input  wire logic                      stop_exec,
	input  wire logic                      bdm_active,
	input  wire logic                      regulator_ready,
	output logic                           cpu_clk_en,
	output logic                           pc_hold,
	output logic                           resume_fetch,
	output logic                           stop_clocks,
	output logic                           ilop_reset,
	output logic                           analog_comparator_pins_gpio,
	output logic                           irq
);
	import wip_pkg::*;

	typedef struct packed {
		wip_pwr_type     pwr;
		logic [1:0]      cnt;
		logic [NSRC-1:0] flags;
		logic [NSRC-1:0] pend;
		logic [NSRC-1:0] en;
		logic [NSRC-1:0] mask;
		logic [1:0]      opt;
		logic            clk_en;
		logic            hold;
		logic            resume;
		logic            stop_clk;
		logic            ilop;
		logic            gpio;
		logic            irq;
	} wip_state_type;

	localparam wip_state_type ST_RESET = '{
		pwr: pwr_run, cnt: 2'h0, flags: 5'h00, pend: 5'h00,
		en: RST_ENABLE, mask: RST_MASK, opt: RST_OPTION,
		clk_en: 1'b1, hold: 1'b0, resume: 1'b0, stop_clk: 1'b0,
		ilop: 1'b0, gpio: 1'b1, irq: 1'b0
	};

	wip_state_type     q;
	wip_state_type     d;
	logic [4:0]        sync_lvl;
	logic [4:0]        sync_rise;
	logic [NSRC-1:0]   evt;
	logic [NSRC-1:0]   evt_en;
	logic [NSRC-1:0]   clr;
	logic              reg_rdy;
	logic              wake_go;
	logic              stop_go;
	logic              kb_ack;
	logic              wr_en;
	logic              wr_b;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [3:0]        wr_strb;
	logic              wr_err;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic              rd_err;

	////////////////////////////////////////////////////////////////////////
	// Bus front end
	wip_axil u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.axi_req (axi_req),
		.axi_rsp (axi_rsp),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_err  (wr_err),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_err  (rd_err)
	);

	// Pins cross into the bus clock; costs four cycles to the rise output
	wip_sync #(
		.WIDTH (5)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     ({regulator_ready, kbd_pin, analog_comparator_pin, rti_pin, lvd_pin}),
		.level   (sync_lvl),
		.rise    (sync_rise)
	);

	////////////////////////////////////////////////////////////////////////
	// Event vector, one bit per source
	assign evt = {sync_rise[3], sync_rise[2], modulo_timer_overflow, sync_rise[1], sync_rise[0]};
	assign reg_rdy = sync_lvl[4];
	assign evt_en = evt & q.en;
	// Debugger owns the core while active, so no wakeup then
	assign wake_go = (|evt_en) & ~bdm_active;
	assign stop_go = (|(evt_en & STOP_CAPABLE)) & ~bdm_active;
	assign wr_b = wr_en & wr_strb[0];
	assign kb_ack = wr_b && wr_addr == OFF_KBSC && wr_data[KB_ACK_BIT];

	////////////////////////////////////////////////////////////////////////
	// Register reads and error answers
	always_comb begin
		rd_err = 1'b0;
		unique case (rd_addr)
			OFF_FLAGS:   rd_data = 32'(q.flags);
			OFF_ENABLE:  rd_data = 32'(q.en);
			OFF_MASK:    rd_data = 32'(q.mask);
			OFF_PENDING: rd_data = 32'(q.pend);
			OFF_KBSC:    rd_data = 32'({q.en[SRC_KBD], q.flags[SRC_KBD]});
			OFF_OPTION:  rd_data = 32'(q.opt);
			OFF_STATE:   rd_data = 32'(q.pwr);
			default: begin
				rd_data = 32'h0000_0000;
				rd_err = 1'b1;
			end
		endcase
	end

	// Read-only locations accept writes silently
	always_comb begin
		unique case (wr_addr)
			OFF_FLAGS, OFF_ENABLE, OFF_MASK, OFF_PENDING,
			OFF_KBSC, OFF_OPTION, OFF_STATE: wr_err = 1'b0;
			default: wr_err = wr_en;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		d = q;
		clr = 5'h00;
		if (wr_b && wr_addr == OFF_FLAGS) begin
			clr = wr_data[NSRC-1:0];
		end
		if (kb_ack) begin
			clr[SRC_KBD] = 1'b1;
		end
		// A fresh event beats a clear in the same cycle
		d.flags = (q.flags & ~clr) | evt;
		// Pending can only hold what its flag holds
		d.pend = (q.pend & ~clr) | evt_en;
		if (wr_b && wr_addr == OFF_ENABLE) begin
			d.en = wr_data[NSRC-1:0];
		end
		if (wr_b && wr_addr == OFF_KBSC) begin
			d.en[SRC_KBD] = wr_data[KB_EN_BIT];
		end
		if (wr_b && wr_addr == OFF_MASK) begin
			d.mask = wr_data[NSRC-1:0];
		end
		if (wr_b && wr_addr == OFF_OPTION) begin
			d.opt = wr_data[1:0];
		end
		d.resume = 1'b0;
		d.ilop = 1'b0;
		unique case (q.pwr)
			pwr_run: begin
				// Events here only land in the flags and pending bits
				if (stop_exec) begin
					if (q.opt[OPT_STOP_PERMIT]) begin
						d.pwr = pwr_stop;
						d.clk_en = 1'b0;
						d.hold = 1'b1;
						d.stop_clk = 1'b1;
					end else begin
						d.ilop = 1'b1;
					end
				end else if (wait_exec) begin
					d.pwr = pwr_wait;
					d.clk_en = 1'b0;
					d.hold = 1'b1;
				end
			end
			pwr_wait: begin
				if (wake_go) begin
					d.pwr = pwr_resume;
					d.cnt = WAKE_CNT_INIT;
				end
			end
			pwr_stop: begin
				if (stop_go) begin
					d.pwr = pwr_recover;
					d.stop_clk = 1'b0;
				end
			end
			pwr_recover: begin
				// Clock and regulator must be back first
				if (reg_rdy) begin
					d.pwr = pwr_resume;
					d.cnt = WAKE_CNT_INIT;
				end
			end
			pwr_resume: begin
				if (q.cnt == 2'h0) begin
					d.pwr = pwr_run;
					d.clk_en = 1'b1;
					d.hold = 1'b0;
					d.resume = 1'b1;
				end else begin
					d.cnt = q.cnt - 2'h1;
				end
			end
			default: begin
				d = ST_RESET;
			end
		endcase
		d.gpio = ~q.opt[OPT_ANALOG_COMPARATOR_EN];
		d.irq = |(d.flags & d.mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= ST_RESET;
		end else begin
			q <= d;
		end
	end

	assign cpu_clk_en     = q.clk_en;
	assign pc_hold        = q.hold;
	assign resume_fetch   = q.resume;
	assign stop_clocks    = q.stop_clk;
	assign ilop_reset     = q.ilop;
	assign analog_comparator_pins_gpio = q.gpio;
	assign irq            = q.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_flag_set;
		|evt |=> (q.flags & $past(evt)) == $past(evt);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event flag not set");

	property p_pend_set;
		|evt_en |=> (q.pend & $past(evt_en)) == $past(evt_en);
	endproperty
	a_pend_set: assert property (p_pend_set) else $error("pending bit not set");

	property p_kb_ack;
		kb_ack && !evt[SRC_KBD] |=> !q.flags[SRC_KBD] && !q.pend[SRC_KBD];
	endproperty
	a_kb_ack: assert property (p_kb_ack) else $error("keyboard ack failed");

	property p_mirror;
		(q.pend & ~q.flags) == 5'h00;
	endproperty
	a_mirror: assert property (p_mirror) else $error("pending without flag");

	property p_wait_wake;
		q.pwr == pwr_wait && wake_go |-> ##3 q.resume && q.clk_en && !q.hold;
	endproperty
	a_wait_wake: assert property (p_wait_wake) else $error("wait wake not in 3");

	property p_no_wake;
		q.pwr == pwr_wait && !wake_go |=> q.pwr == pwr_wait;
	endproperty
	a_no_wake: assert property (p_no_wake) else $error("disabled source woke");

	property p_stop_sync;
		q.pwr == pwr_stop && !stop_go |=> q.pwr == pwr_stop && q.stop_clk;
	endproperty
	a_stop_sync: assert property (p_stop_sync) else $error("bad stop wakeup");

	property p_recover;
		q.pwr == pwr_recover && !reg_rdy |=> q.pwr == pwr_recover && !q.clk_en;
	endproperty
	a_recover: assert property (p_recover) else $error("resumed before ready");

	property p_run_flow;
		q.pwr == pwr_run && !wait_exec && !stop_exec |=> q.pwr == pwr_run && !q.resume;
	endproperty
	a_run_flow: assert property (p_run_flow) else $error("event changed run flow");

	property p_wait_gate;
		q.pwr == pwr_run && wait_exec && !stop_exec |=> (!q.clk_en && q.hold) [*2];
	endproperty
	a_wait_gate: assert property (p_wait_gate) else $error("wait did not gate");

	property p_stop_deny;
		q.pwr == pwr_run && stop_exec && !q.opt[OPT_STOP_PERMIT] |=> q.ilop && q.clk_en;
	endproperty
	a_stop_deny: assert property (p_stop_deny) else $error("stop without permit");

	c_wait_wake: cover property (q.pwr == pwr_wait ##1 q.pwr == pwr_resume);
	c_stop_wake: cover property (q.pwr == pwr_recover ##1 q.pwr == pwr_resume);
	c_kb_ack: cover property (q.pend[SRC_KBD] ##1 kb_ack);
endmodule
`default_nettype wire

// >>> wip_partner.sv
// Clock module and regulator standby model seen by the stop recovery path
`default_nettype none
module wip_partner (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Stop request and chosen recovery speed
	input  wire logic       stop_clocks,
	input  wire logic [3:0] ready_delay,
	// Standby release
	output logic            regulator_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q;
	// Standby while clocks are halted; slow release shows whether the core waits for it
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 4'h0;
			regulator_ready <= 1'b1;
		end else if (stop_clocks) begin
			cnt_q <= 4'h0;
			regulator_ready <= 1'b0;
		end else if (!regulator_ready) begin
			cnt_q <= cnt_q + 4'h1;
			regulator_ready <= (cnt_q >= ready_delay);
		end
	end
endmodule
`default_nettype wire

// >>> wip_top_tb.sv
// Self-checking bench for the wakeup and pending-flag block
`default_nettype none
module wip_top_tb import wip_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	wip_axi_req_type req;
	wip_axi_rsp_type rsp;
	logic aclk, aresetn, lvd_pin, rti_pin, analog_comparator_pin, kbd_pin, modulo_timer_overflow;
	logic wait_exec, stop_exec, bdm_active, regulator_ready, cpu_clk_en, pc_hold;
	logic resume_fetch, stop_clocks, ilop_reset, analog_comparator_pins_gpio, irq;
	logic [3:0]  ready_delay;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	logic [31:0] v, p;
	int          err_total, check_count, cyc, seed, k, rf_count, rr_age, rf0;
	localparam logic [7:0]  OFFS[7] = '{OFF_FLAGS, OFF_ENABLE, OFF_MASK, OFF_PENDING,
		OFF_KBSC, OFF_OPTION, OFF_STATE};
	localparam logic [31:0] RSTV[7] = '{0, 0, 0, 0, 0, 0, 32'h1};

	wip_top i_dut (.aclk, .aresetn, .axi_req(req), .axi_rsp(rsp), .lvd_pin, .rti_pin,
		.analog_comparator_pin, .kbd_pin, .modulo_timer_overflow, .wait_exec, .stop_exec, .bdm_active,
		.regulator_ready, .cpu_clk_en, .pc_hold, .resume_fetch, .stop_clocks, .ilop_reset,
		.analog_comparator_pins_gpio, .irq);
	wip_partner i_far (.aclk, .aresetn, .stop_clocks, .ready_delay, .regulator_ready);

	////////////////////////////////////////////////////////////////////////////////
	always #20 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		rr_age <= regulator_ready ? rr_age + 1 : 0;
		if (cyc == 6000) begin
			err_total++;
			$display("[ERR] run length expected 6000 seen hang");
			end_of_test;
		end
	end
	// Answers are sampled mid-cycle, clear of the edge that launches them
	always @(negedge aclk) begin
		if (resume_fetch === 1'b1) rf_count++;
		if (rsp.rvalid && req.rready && rq.size() > 0) chk("read", rq.pop_front(),
			{rsp.rresp, rsp.rdata});
		if (rsp.bvalid && req.bready && bq.size() > 0) chk("bresp", 34'(bq.pop_front()),
			34'(rsp.bresp));
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic da, dw, ha, hw, hb;
		da = 0;
		dw = 0;
		hb = 0;
		bq.push_back(e);
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.bready <= 1'b1;
		while (!(da && dw)) begin
			@(negedge aclk);
			ha = rsp.awready && !da;
			hw = rsp.wready && !dw;
			@(posedge aclk);
			if (ha) req.awvalid <= 1'b0;
			if (hw) req.wvalid <= 1'b0;
			da = da | ha;
			dw = dw | hw;
		end
		while (!hb) begin
			@(negedge aclk);
			hb = rsp.bvalid;
			@(posedge aclk);
		end
		req.bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		logic h;
		h = 0;
		rq.push_back(e);
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		while (!h) begin
			@(negedge aclk);
			h = rsp.arready;
			@(posedge aclk);
		end
		req.arvalid <= 1'b0;
		h = 0;
		while (!h) begin
			@(negedge aclk);
			h = rsp.rvalid;
			@(posedge aclk);
		end
		req.rready <= 1'b0;
	endtask
	task automatic core(input logic stp);
		if (stp) stop_exec <= 1'b1;
		else wait_exec <= 1'b1;
		@(posedge aclk);
		stop_exec <= 1'b0;
		wait_exec <= 1'b0;
	endtask
	task automatic tmr;
		modulo_timer_overflow <= 1'b1;
		@(posedge aclk);
		modulo_timer_overflow <= 1'b0;
	endtask
	// Cycles until resume (sel 1) or irq (sel 0), ending on a rising edge
	task automatic cnt(input logic sel, output int n);
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!(sel ? resume_fetch : irq) && n < 40);
		@(posedge aclk);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{aclk, lvd_pin, rti_pin, analog_comparator_pin, kbd_pin, modulo_timer_overflow} = '0;
		{wait_exec, stop_exec, bdm_active, aresetn} = '0;
		{err_total, check_count, cyc, rf_count, rr_age} = '0;
		seed = 1190;
		ready_delay = 4'h0;
		req = '0;
		req.wstrb = 4'hf;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++) rd(OFFS[i], {2'h0, RSTV[i]});
		chk("gpio", 1, analog_comparator_pins_gpio);
		rd(8'h40, {RESP_SLVERR, 32'h0});
		wr(8'h40, 32'h1f, RESP_SLVERR);
		wr(OFF_PENDING, 32'h1f, RESP_OKAY);
		v = $random(seed);
		wr(OFF_MASK, v, RESP_OKAY);
		rd(OFF_MASK, {2'h0, 27'h0, v[4:0]});
		wr(OFF_MASK, 32'h1f, RESP_OKAY);
		$display("test bus done");
		tmr;
		chk("run", 1, {rf_count[0], cpu_clk_en});
		rd(OFF_FLAGS, 34'h4);
		rd(OFF_PENDING, 34'h0);
		chk("irq", 1, irq);
		wr(OFF_ENABLE, 32'h4, RESP_OKAY);
		tmr;
		rd(OFF_PENDING, 34'h4);
		wr(OFF_MASK, 32'h0, RESP_OKAY);
		chk("irq masked", 0, irq);
		wr(OFF_MASK, 32'h1f, RESP_OKAY);
		wr(OFF_FLAGS, 32'h4, RESP_OKAY);
		rd(OFF_PENDING, 34'h0);
		chk("irq", 0, irq);
		$display("test flags done");
		wr(OFF_KBSC, 32'h2, RESP_OKAY);
		rd(OFF_ENABLE, 34'h14);
		kbd_pin <= 1'b1;
		cnt(1'b0, k);
		// Three sync stages, rise flop, then flag and irq flops on one edge, plus the first sample before any edge
		chk("sync", 6, k);
		rd(OFF_KBSC, 34'h3);
		rd(OFF_PENDING, 34'h10);
		wr(OFF_KBSC, 32'h6, RESP_OKAY);
		rd(OFF_KBSC, 34'h2);
		rd(OFF_PENDING, 34'h0);
		kbd_pin <= 1'b0;
		$display("test keyboard done");
		wr(OFF_ENABLE, 32'h4, RESP_OKAY);
		core(1'b0);
		repeat (2) @(posedge aclk);
		chk("wait", 2, {pc_hold, cpu_clk_en});
		rf0 = rf_count;
		lvd_pin <= 1'b1;
		repeat (12) @(posedge aclk);
		chk("disabled wake", rf0, rf_count);
		rd(OFF_STATE, 34'h2);
		modulo_timer_overflow <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			@(negedge aclk);
			v[i] = resume_fetch;
			p[i] = pc_hold;
			@(posedge aclk);
			modulo_timer_overflow <= 1'b0;
		end
		chk("resume", 5'b01000, v[4:0]);
		chk("hold", 5'b00111, p[4:0]);
		chk("clk", 1, cpu_clk_en);
		lvd_pin <= 1'b0;
		wr(OFF_FLAGS, 32'h1f, RESP_OKAY);
		$display("test wait done");
		core(1'b1);
		k = 0;
		repeat (3) begin
			@(negedge aclk);
			k += ilop_reset;
		end
		@(posedge aclk);
		chk("ilop", 1, k);
		rd(OFF_STATE, 34'h1);
		wr(OFF_OPTION, 32'h1, RESP_OKAY);
		wr(OFF_ENABLE, 32'h5, RESP_OKAY);
		ready_delay <= 4'($random(seed) & 7);
		rf0 = rf_count;
		core(1'b1);
		repeat (3) @(posedge aclk);
		tmr;
		repeat (8) @(posedge aclk);
		chk("stop", {rf0, 1'b1}, {rf_count, stop_clocks});
		lvd_pin <= 1'b1;
		cnt(1'b1, k);
		chk("recovery", 1, rr_age >= 3);
		// Pin sync, event, regulator release and its sync, then three resume cycles
		chk("recovery time", 14 + ready_delay, k);
		chk("stop off", 0, stop_clocks);
		lvd_pin <= 1'b0;
		$display("test stop done");
		wr(OFF_FLAGS, 32'h1f, RESP_OKAY);
		bdm_active <= 1'b1;
		core(1'b0);
		rf0 = rf_count;
		tmr;
		repeat (10) @(posedge aclk);
		chk("debug", rf0, rf_count);
		bdm_active <= 1'b0;
		wr(OFF_FLAGS, 32'h1f, RESP_OKAY);
		rf0 = rf_count;
		tmr;
		repeat (8) @(posedge aclk);
		chk("wake", rf0 + 1, rf_count);
		wr(OFF_OPTION, 32'h3, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("gpio", 0, analog_comparator_pins_gpio);
		wr(OFF_OPTION, 32'h1, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("gpio", 1, analog_comparator_pins_gpio);
		$display("test debug and pins done");
		end_of_test;
	end
endmodule
`default_nettype wire
